// ===== rtl/bct_decode.sv
/*
  combinational opcode classifier: byte length, base cycles, operand and flow class.
  assumes an opcode from the same clock domain; no state is kept here.
*/
`timescale 1ns/10ps
module bct_decode
  import bct_pkg::*;
(
  // opcode in
  input wire logic [7:0] opcode,
  // decode results
  output logic [1:0] length,
  output logic [3:0] base_cycles,
  output bct_pkg::bct_amode_t amode,
  output bct_pkg::bct_flow_t flow,
  output logic clear_bit
);
  logic [3:0] lo;
  logic [3:0] hi;

  assign lo = opcode[3:0];
  assign hi = opcode[7:4];

  // table walk in opcode-map order; cycles equal bytes unless listed otherwise
  always_comb begin
    length = 2'd1;
    base_cycles = 4'h1;
    amode = BCT_AM_NONE;
    flow = BCT_FL_SEQ;
    clear_bit = 1'b0;
    if (lo >= 4'h8) begin
      amode = BCT_AM_REG;
      if (hi == 4'h7 || hi == 4'h8 || hi == 4'ha || hi == 4'hd) begin
        length = 2'd2;
        base_cycles = 4'h2;
      end
      if (hi == 4'hb) begin
        length = 2'd3;
        base_cycles = 4'h3;
        flow = BCT_FL_COND;
      end
      if (hi == 4'hd) flow = BCT_FL_COND;
    end else if (lo == 4'h6 || lo == 4'h7) begin
      amode = BCT_AM_IND;
      base_cycles = 4'h2;
      if (hi == 4'h7 || hi == 4'h8 || hi == 4'ha) length = 2'd2;
      if (hi == 4'hb) begin
        length = 2'd3;
        base_cycles = `BCT_CYC_CJNE_IND;
        flow = BCT_FL_COND;
      end
    end else if (lo == 4'h5) begin
      amode = BCT_AM_DIR;
      length = 2'd2;
      base_cycles = 4'h2;
      if (hi == 4'h7 || hi == 4'h8 || hi == 4'hb || hi == 4'hd) begin
        length = 2'd3;
        base_cycles = 4'h3;
      end
      if (hi == 4'hb || hi == 4'hd) flow = BCT_FL_COND;
      if (opcode == `BCT_OP_SPARE) begin
        amode = BCT_AM_NONE;
        length = 2'd1;
        base_cycles = 4'h1;
      end
    end else if (lo[3:0] == 4'h1) begin
      length = 2'd2;
      base_cycles = `BCT_CYC_ABS;
      flow = BCT_FL_ABS11;
    end else begin
      case (opcode)
        // plain no-operation; column 0 otherwise holds forms of one to three bytes
        `BCT_OP_NOP: base_cycles = 4'h1;
        `BCT_OP_CJNE_AI: begin
          length = 2'd3;
          base_cycles = 4'h3;
          flow = BCT_FL_COND;
        end
        `BCT_OP_LJMP, `BCT_OP_LCALL: begin
          length = 2'd3;
          base_cycles = `BCT_CYC_LONG;
          flow = BCT_FL_LONG;
        end
        `BCT_OP_SJMP: begin
          length = 2'd2;
          base_cycles = `BCT_CYC_ABS;
          flow = BCT_FL_REL;
        end
        `BCT_OP_JMP_IND: begin
          base_cycles = `BCT_CYC_ABS;
          flow = BCT_FL_IND;
        end
        `BCT_OP_RET, `BCT_OP_RETI: begin
          base_cycles = `BCT_CYC_RET;
          flow = BCT_FL_RET;
        end
        `BCT_OP_JBC, `BCT_OP_JB, `BCT_OP_JNB: begin
          length = 2'd3;
          base_cycles = 4'h3;
          amode = BCT_AM_BIT;
          flow = BCT_FL_COND;
          clear_bit = (opcode == `BCT_OP_JBC);
        end
        `BCT_OP_JC, `BCT_OP_JNC, `BCT_OP_JZ, `BCT_OP_JNZ: begin
          length = 2'd2;
          base_cycles = 4'h2;
          flow = BCT_FL_COND;
        end
        `BCT_OP_MOV_DP: begin
          length = 2'd3;
          base_cycles = 4'h3;
        end
        `BCT_OP_MOVC_PC, `BCT_OP_MOVC_DP: begin
          amode = BCT_AM_CODE;
          base_cycles = `BCT_CYC_MOVC_MIN;
        end
        `BCT_OP_MUL: base_cycles = `BCT_CYC_MUL;
        `BCT_OP_DIV: base_cycles = `BCT_CYC_DIV;
        8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3: begin
          amode = BCT_AM_XDATA;
          base_cycles = `BCT_CYC_MOVX;
        end
        default: begin
          // rows 4..7 col 2..4, bit ops, push/pop and one-byte accumulator ops
          if (lo == 4'h2) begin
            length = 2'd2;
            base_cycles = 4'h2;
            amode = (hi >= 4'h7) ? BCT_AM_BIT : BCT_AM_DIR;
          end else if (lo == 4'h3 && hi >= 4'h4 && hi <= 4'h6) begin
            // rows 4..6 of column 3 take a direct address and an immediate: three bytes
            length = 2'd3;
            base_cycles = 4'h3;
            amode = BCT_AM_DIR;
          end else if (lo == 4'h0) begin
            length = 2'd2;
            base_cycles = 4'h2;
            amode = BCT_AM_DIR;
          end else if (lo == 4'h4 && hi >= 4'h2 && hi <= 4'h9) begin
            length = 2'd2;
            base_cycles = 4'h2;
          end else if (lo == 4'h4 && hi == 4'h7) begin
            length = 2'd2;
            base_cycles = 4'h2;
          end else begin
            base_cycles = 4'h1;
          end
        end
      endcase
    end
  end
endmodule : bct_decode

// ===== rtl/bct_defines.svh
/*
  timing and encoding constants for the instruction decode and timing block.
  assumes inclusion by bare name from the package; the design files use its macros without including it.
*/
`ifndef BCT_DEFINES_SVH
`define BCT_DEFINES_SVH

`define BCT_OP_NOP 8'h00
`define BCT_OP_SPARE 8'ha5
`define BCT_OP_MOVC_PC 8'h83
`define BCT_OP_MOVC_DP 8'h93
`define BCT_OP_JMP_IND 8'h73
`define BCT_OP_SJMP 8'h80
`define BCT_OP_LJMP 8'h02
`define BCT_OP_LCALL 8'h12
`define BCT_OP_MOV_DP 8'h90
`define BCT_OP_JBC 8'h10
`define BCT_OP_JB 8'h20
`define BCT_OP_JNB 8'h30
`define BCT_OP_JC 8'h40
`define BCT_OP_JNC 8'h50
`define BCT_OP_JZ 8'h60
`define BCT_OP_JNZ 8'h70
`define BCT_OP_CJNE_AD 8'hb5
`define BCT_OP_CJNE_AI 8'hb4
`define BCT_OP_DJNZ_D 8'hd5
`define BCT_OP_PUSH 8'hc0
`define BCT_OP_POP 8'hd0
`define BCT_OP_XCHD_0 8'hd6
`define BCT_OP_XCHD_1 8'hd7
`define BCT_OP_MUL 8'ha4
`define BCT_OP_DIV 8'h84
`define BCT_OP_RET 8'h22
`define BCT_OP_RETI 8'h32

`define BCT_SFR_BOUND 8'h80
`define BCT_PAGE_MASK 16'hf800
`define BCT_CYC_MOVC_MIN 4'h4
`define BCT_CYC_MOVC_MAX 4'h7
`define BCT_CYC_MOVX 4'h3
`define BCT_CYC_ABS 4'h4
`define BCT_CYC_LONG 4'h5
`define BCT_CYC_RET 4'h6
`define BCT_CYC_MUL 4'h4
`define BCT_CYC_DIV 4'h8
`define BCT_CYC_CJNE_IND 4'h4
`define BCT_CYC_TAKEN_EXTRA 4'h2

`endif

// ===== rtl/bct_pkg.sv
/*
  types shared by the instruction decode and timing block.
  assumes bct_defines.svh is on the include path.
*/
package bct_pkg;
  `include "bct_defines.svh"

  // operand addressing class of the decoded opcode
  typedef enum logic [2:0] {
    BCT_AM_NONE,
    BCT_AM_REG,
    BCT_AM_IND,
    BCT_AM_DIR,
    BCT_AM_BIT,
    BCT_AM_CODE,
    BCT_AM_XDATA
  } bct_amode_t;

  // how the program counter moves after the instruction
  typedef enum logic [2:0] {
    BCT_FL_SEQ,
    BCT_FL_COND,
    BCT_FL_REL,
    BCT_FL_ABS11,
    BCT_FL_LONG,
    BCT_FL_IND,
    BCT_FL_RET
  } bct_flow_t;
endpackage : bct_pkg

// ===== rtl/bct_timing.sv
/*
  instruction timing sequencer: accepts one opcode with operands, counts its cycles,
  resolves the branch target and operand addresses, and marks completion.
  assumes opcode, operand bytes, branch outcome and current pc come from same-clock
  core logic; prefetch is taken to be on, the only setting this timing covers.
*/
`timescale 1ns/10ps
module bct_timing
  import bct_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // instruction issue
  input wire logic ISSUE,
  input wire logic [7:0] OPCODE,
  input wire logic [7:0] OPERAND1,
  input wire logic [7:0] OPERAND2,
  input wire logic [15:0] NEXT_PC,
  input wire logic [15:0] DATA_POINTER,
  input wire logic [7:0] ACC,
  input wire logic COND_TRUE,
  input wire logic [1:0] BANK_SELECT,
  input wire logic [7:0] PTR_REG_VALUE,
  // flash timing
  input wire logic [1:0] MOVC_EXTRA,
  // results
  output logic BUSY,
  output logic DONE,
  output logic [1:0] LENGTH,
  output logic [3:0] CYCLES,
  output logic BRANCH,
  output logic [15:0] TARGET,
  output logic [7:0] DATA_ADDR,
  output logic SFR_SELECT,
  output logic CLEAR_BIT
);
  import bct_pkg::*;

  logic [1:0] dec_length;
  logic [3:0] dec_cycles;
  bct_amode_t dec_amode;
  bct_flow_t dec_flow;
  logic dec_clear;
  logic [3:0] total_cycles;
  logic taken;
  logic [15:0] target_next;
  logic [7:0] addr_next;

  logic busy_reg;
  logic done_reg;
  logic [3:0] count_reg;
  logic [1:0] length_reg;
  logic [3:0] cycles_reg;
  logic branch_reg;
  logic [15:0] target_reg;
  logic [7:0] addr_reg;
  logic sfr_reg;
  logic clear_reg;

  // sign-extended relative offset added to the following instruction address
  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] off);
    rel_target = pc + {{8{off[7]}}, off};
  endfunction : rel_target

  // opcode map decode, shared table for length and base cost
  bct_decode u_decode (
    .opcode(OPCODE),
    .length(dec_length),
    .base_cycles(dec_cycles),
    .amode(dec_amode),
    .flow(dec_flow),
    .clear_bit(dec_clear)
  );

  // branch outcome; unconditional transfers are always taken
  assign taken = (dec_flow != BCT_FL_SEQ) && (dec_flow != BCT_FL_COND || COND_TRUE);

  // cost: not-taken is the base, taken adds two; code loads add flash wait
  always_comb begin
    total_cycles = dec_cycles;
    if (dec_flow == BCT_FL_COND && COND_TRUE) begin
      total_cycles = dec_cycles + `BCT_CYC_TAKEN_EXTRA;
    end
    if (dec_amode == BCT_AM_CODE) begin
      total_cycles = `BCT_CYC_MOVC_MIN + {2'b00, MOVC_EXTRA};
    end
  end

  // destination address by flow class
  always_comb begin
    case (dec_flow)
      BCT_FL_COND: target_next = rel_target(NEXT_PC, (dec_length == 2'd3) ? OPERAND2 : OPERAND1);
      BCT_FL_REL: target_next = rel_target(NEXT_PC, OPERAND1);
      BCT_FL_ABS11: target_next = (NEXT_PC & `BCT_PAGE_MASK) | {5'h00, OPCODE[7:5], OPERAND1};
      BCT_FL_LONG: target_next = {OPERAND1, OPERAND2};
      BCT_FL_IND: target_next = DATA_POINTER + {8'h00, ACC};
      default: target_next = NEXT_PC;
    endcase
  end

  // data-space address for the operand; registers map into the selected bank
  always_comb begin
    case (dec_amode)
      BCT_AM_REG: addr_next = {3'b000, BANK_SELECT, OPCODE[2:0]};
      BCT_AM_IND: addr_next = PTR_REG_VALUE;
      BCT_AM_DIR: addr_next = OPERAND1;
      BCT_AM_BIT: addr_next = OPERAND1;
      default: addr_next = 8'h00;
    endcase
  end

  // cycle counter: busy from issue until the last cycle of the instruction
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      busy_reg <= 1'b0;
      count_reg <= 4'h0;
    end else if (ISSUE && !busy_reg) begin
      busy_reg <= (total_cycles > 4'h1);
      count_reg <= total_cycles - 4'h1;
    end else if (busy_reg) begin
      count_reg <= count_reg - 4'h1;
      if (count_reg == 4'h1) busy_reg <= 1'b0;
    end
  end

  // one-cycle completion pulse in the instruction's last cycle
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (ISSUE && !busy_reg && total_cycles == 4'h1) || (busy_reg && count_reg == 4'h1);
    end
  end

  // decoded results captured at issue, held until the next issue
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      length_reg <= 2'd0;
      cycles_reg <= 4'h0;
      branch_reg <= 1'b0;
      target_reg <= 16'h0000;
      addr_reg <= 8'h00;
      sfr_reg <= 1'b0;
      clear_reg <= 1'b0;
    end else if (ISSUE && !busy_reg) begin
      length_reg <= dec_length;
      cycles_reg <= total_cycles;
      branch_reg <= taken;
      target_reg <= taken ? target_next : NEXT_PC;
      addr_reg <= addr_next;
      sfr_reg <= (dec_amode == BCT_AM_DIR || dec_amode == BCT_AM_BIT) && (addr_next >= `BCT_SFR_BOUND);
      clear_reg <= dec_clear && COND_TRUE;
    end
  end

  // outputs straight from flip-flops
  assign BUSY = busy_reg;
  assign DONE = done_reg;
  assign LENGTH = length_reg;
  assign CYCLES = cycles_reg;
  assign BRANCH = branch_reg;
  assign TARGET = target_reg;
  assign DATA_ADDR = addr_reg;
  assign SFR_SELECT = sfr_reg;
  assign CLEAR_BIT = clear_reg;
endmodule : bct_timing

// ===== sim/bct_core_model.sv
/*
  working register model: gives the r0 or r1 content of the selected bank.
  assumes the bench drives bank select and opcode; answers at once.
*/
`timescale 1ns/10ps
module bct_core_model (
  // selection
  input wire logic [7:0] opcode,
  input wire logic [1:0] bank_select,
  // pointer content
  output logic [7:0] ptr_reg_value
);
  // each bank has its own eight registers; only r0 or r1 can point
  assign ptr_reg_value = 8'({bank_select, 2'b00, opcode[0]} * 37 + 5);
endmodule : bct_core_model

// ===== sim/bct_timing_props.sv
/*
  port checker for the timing sequencer.
  assumes one clock domain and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
module bct_timing_props (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // issue side
  input wire logic ISSUE,
  input wire logic [7:0] OPCODE,
  input wire logic [7:0] OPERAND1,
  input wire logic [15:0] NEXT_PC,
  input wire logic COND_TRUE,
  input wire logic [1:0] MOVC_EXTRA,
  // results
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic [1:0] LENGTH,
  input wire logic [3:0] CYCLES,
  input wire logic BRANCH,
  input wire logic [15:0] TARGET,
  input wire logic [7:0] DATA_ADDR,
  input wire logic SFR_SELECT,
  input wire logic CLEAR_BIT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // an issue is only taken while idle
  logic take;
  assign take = ISSUE && !BUSY;

  busy_first_a: assert property (take |=> (BUSY == (CYCLES != 4'h1)) && (DONE == (CYCLES == 4'h1)))
    else $error("busy or done wrong after issue");
  busy_end_a: assert property ($fell(BUSY) |-> DONE)
    else $error("busy dropped without done");
  result_hold_a: assert property (BUSY |=> $stable(TARGET) && $stable(CYCLES))
    else $error("results moved while busy");
  spare_nop_a: assert property (take && OPCODE == 8'ha5 |=> LENGTH == 2'h1 && CYCLES == 4'h1 && !BRANCH)
    else $error("spare opcode not a nop");
  ext_move_a: assert property (take && OPCODE inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3}
    |=> CYCLES == 4'h3 && LENGTH == 2'h1)
    else $error("external move timing wrong");
  code_load_a: assert property (take && (OPCODE == 8'h83 || OPCODE == 8'h93)
    |=> CYCLES == 4'h4 + {2'h0, $past(MOVC_EXTRA)})
    else $error("code load timing wrong");
  short_cond_a: assert property (take && OPCODE == 8'h40 && !COND_TRUE
    |=> CYCLES == 4'h2 && !BRANCH && TARGET == $past(NEXT_PC) ##1 DONE)
    else $error("not taken jump wrong");
  rel_target_a: assert property (take && OPCODE == 8'h80
    |=> BRANCH && TARGET == $past(NEXT_PC) + {{8{$past(OPERAND1[7])}}, $past(OPERAND1)})
    else $error("relative target wrong");
  page_keep_a: assert property (take && OPCODE[4:0] == 5'h01
    |=> TARGET[15:11] == $past(NEXT_PC[15:11]) && CYCLES == 4'h4)
    else $error("absolute jump left its page");
  direct_space_a: assert property (take && OPCODE == 8'h75
    |=> DATA_ADDR == $past(OPERAND1) && SFR_SELECT == $past(OPERAND1[7]))
    else $error("direct address split wrong");
  clear_only_a: assert property (take && !(OPCODE == 8'h10 && COND_TRUE) |=> !CLEAR_BIT)
    else $error("bit clear without cause");
endmodule : bct_timing_props

bind bct_timing bct_timing_props i_bct_timing_props (.CLOCK(CLOCK), .RSTN(RSTN), .ISSUE(ISSUE), .OPCODE(OPCODE),
  .OPERAND1(OPERAND1), .NEXT_PC(NEXT_PC), .COND_TRUE(COND_TRUE), .MOVC_EXTRA(MOVC_EXTRA), .BUSY(BUSY),
  .DONE(DONE), .LENGTH(LENGTH), .CYCLES(CYCLES), .BRANCH(BRANCH), .TARGET(TARGET), .DATA_ADDR(DATA_ADDR),
  .SFR_SELECT(SFR_SELECT), .CLEAR_BIT(CLEAR_BIT));

// ===== sim/tb.sv
/*
  self-checking bench for the timing sequencer.
  assumes a 250 MHz clock and the working register model beside the design.
*/
`timescale 1ns/10ps
module tb;
  import bct_pkg::*;
  typedef struct packed {
    logic [1:0] len;
    logic [3:0] cyc;
    logic br;
    logic [15:0] tgt;
    logic clr;
    logic dk;
    logic [7:0] da;
    logic sk;
  } bct_exp_t;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic issue = 1'b0;
  logic cond = 1'b0;
  logic [7:0] opcode = 8'h00, op1 = 8'h00, op2 = 8'h00, acc = 8'h00, ptr, da;
  logic [15:0] next_pc = 16'h0000, dp = 16'h0000, tgt;
  logic [1:0] bank = 2'h0, mx = 2'h0, len;
  logic busy, done, br, sfr, clr;
  logic [3:0] cyc;
  bct_exp_t q[$];
  bct_exp_t m;
  int bad_count = 0;
  int num_checks = 0;
  int seed = 32'h0a21;
  logic [7:0] ops [0:37] = '{8'h00, 8'ha5, 8'h2b, 8'he4, 8'hc3, 8'hc4, 8'h26, 8'hd6, 8'hc7, 8'hc2, 8'h72, 8'hc0,
    8'hd0, 8'h75, 8'h85, 8'h90, 8'he0, 8'hf2, 8'h83, 8'h93, 8'h40, 8'h60, 8'hd8, 8'h20, 8'h10, 8'hb5, 8'hd5,
    8'hb6, 8'h80, 8'h01, 8'h11, 8'he1, 8'h73, 8'h02, 8'h12, 8'hb4, 8'h03, 8'h43};

  always #2 clock = ~clock;

  bct_timing i_bct_timing (.CLOCK(clock), .RSTN(rstn), .ISSUE(issue), .OPCODE(opcode), .OPERAND1(op1),
    .OPERAND2(op2), .NEXT_PC(next_pc), .DATA_POINTER(dp), .ACC(acc), .COND_TRUE(cond), .BANK_SELECT(bank),
    .PTR_REG_VALUE(ptr), .MOVC_EXTRA(mx), .BUSY(busy), .DONE(done), .LENGTH(len), .CYCLES(cyc), .BRANCH(br),
    .TARGET(tgt), .DATA_ADDR(da), .SFR_SELECT(sfr), .CLEAR_BIT(clr));
  bct_core_model i_bct_core_model (.opcode(opcode), .bank_select(bank), .ptr_reg_value(ptr));

  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // expected result worked out from the current inputs
  function automatic bct_exp_t exp_of();
    bct_exp_t e;
    logic [15:0] rel;
    logic cj;
    e = '0;
    cj = 1'b0;
    rel = next_pc + {{8{op1[7]}}, op1};
    case (opcode)
      8'h00, 8'ha5, 8'he4, 8'hc3, 8'hc4, 8'h03: {e.len, e.cyc} = {2'h1, 4'h1};
      8'h2b: {e.len, e.cyc, e.dk, e.da} = {2'h1, 4'h1, 1'b1, 3'h0, bank, 3'h3};
      8'h26, 8'hd6, 8'hc7: {e.len, e.cyc, e.dk, e.da} = {2'h1, 4'h2, 1'b1, ptr};
      8'hc2, 8'h72, 8'hc0, 8'hd0: {e.len, e.cyc} = {2'h2, 4'h2};
      8'h75: {e.len, e.cyc, e.dk, e.da, e.sk} = {2'h3, 4'h3, 1'b1, op1, 1'b1};
      8'h85, 8'h90, 8'h43: {e.len, e.cyc} = {2'h3, 4'h3};
      8'he0, 8'hf2: {e.len, e.cyc} = {2'h1, 4'h3};
      8'h83, 8'h93: {e.len, e.cyc} = {2'h1, 4'h4 + {2'h0, mx}};
      8'h40, 8'h60, 8'hd8: {e.len, e.cyc, cj} = {2'h2, 4'h2, 1'b1};
      8'hb6: {e.len, e.cyc, cj, rel} = {2'h3, 4'h4, 1'b1, next_pc + {{8{op2[7]}}, op2}};
      8'h80: {e.len, e.cyc, e.br} = {2'h2, 4'h4, 1'b1};
      8'h01, 8'h11, 8'he1: {e.len, e.cyc, e.br, rel} = {2'h2, 4'h4, 1'b1, next_pc[15:11], opcode[7:5], op1};
      8'h73: {e.len, e.cyc, e.br, rel} = {2'h1, 4'h4, 1'b1, dp + {8'h00, acc}};
      8'h02, 8'h12: {e.len, e.cyc, e.br, rel} = {2'h3, 4'h5, 1'b1, op1, op2};
      default: {e.len, e.cyc, cj, rel} = {2'h3, 4'h3, 1'b1, next_pc + {{8{op2[7]}}, op2}};
    endcase
    // a taken conditional costs two cycles more
    if (cj) {e.br, e.cyc} = {cond, e.cyc + (cond ? 4'h2 : 4'h0)};
    e.tgt = e.br ? rel : next_pc;
    e.clr = (opcode == 8'h10) && cond;
    return e;
  endfunction : exp_of

  // junk issues while busy must be ignored, then the real one goes out
  task automatic go(input logic [7:0] op);
    @(negedge clock);
    while (busy === 1'b1) begin
      opcode = 8'($random(seed));
      next_pc = 16'($random(seed));
      @(negedge clock);
    end
    {opcode, op1, op2, acc} = {op, 24'($random(seed))};
    {next_pc, dp} = 32'($random(seed));
    {cond, bank, mx} = 5'($random(seed));
    issue = 1'b1;
    #1;
    q.push_back(exp_of());
  endtask : go

  // results stand through the done cycle
  always @(negedge clock) begin
    if (done === 1'b1 && q.size() > 0) begin
      m = q.pop_front();
      cmp(16'(m.len), 16'(len));
      cmp(16'(m.cyc), 16'(cyc));
      cmp(16'(m.br), 16'(br));
      cmp(m.tgt, tgt);
      cmp(16'(m.clr), 16'(clr));
      if (m.dk) cmp(16'(m.da), 16'(da));
      if (m.sk) cmp(16'(m.da[7]), 16'(sfr));
    end
  end

  initial begin
    repeat (16) @(negedge clock);
    cmp(16'({busy, done, br, clr}), 16'h0000);
    rstn = 1'b1;
    for (int k = 0; k < 38; k++) go(ops[k]);
    $display("test classes done");
    for (int k = 0; k < 400; k++) go(ops[$unsigned($random(seed)) % 38]);
    $display("test random done");
    @(negedge clock);
    issue = 1'b0;
    repeat (12) @(negedge clock);
    cmp(16'(q.size()), 16'h0000);
    conclude();
  end

  // watchdog well beyond the longest expected run
  initial begin
    #40000;
    bad_count++;
    conclude();
  end
endmodule : tb
